// *** ocq_pkg.sv ***
// Package: register map, field layout, reset values and types of the trim bank
// Operation
// - Amplitude trim bit 5 enables the LNA I/Q test pattern; resets to zero.
// - Amplitude trim bit 4 enables the mixer I/Q test pattern; resets to zero.
// - Amplitude trim bits 3-0 hold the I/Q amplitude balance trim; reset 1000.
// - Phase trim bits 5-0 hold the I/Q phase balance trim; reset 10_0000.
// - Three consecutive registers form the 20-bit lower-limit frequency value.
// - Five-bit span code: thermometer 1.125 to 36 MHz, others zero; reset 9 MHz.
// - Calibration completion stores low and high codes; software may access both.
// - Current code bit 7 picks automatic (0) or forced (1) mode; resets zero.
// - Automatic mode reports the code in use, updated on radio on commands.
// - Forced mode applies the written code; written code ignored in automatic.
// - Software writes start bit one; device clears it when calibration completes.
package ocq_pkg;

   //----------------------------------------------------------------
   // Bus and field widths
   //----------------------------------------------------------------
   localparam int APB_AW  = 8;
   localparam int CODE_W  = 7;
   localparam int FREQ_W  = 20;
   localparam int SPAN_W  = 5;
   localparam int UNITS_W = 6;
   localparam int IRQ_NUM = 2;

   //----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   //----------------------------------------------------------------
   localparam logic [5:0] IDX_AMP_TRIM   = 6'h14;
   localparam logic [5:0] IDX_PHASE_TRIM = 6'h15;
   localparam logic [5:0] IDX_LOWF_B0    = 6'h16;
   localparam logic [5:0] IDX_LOWF_B1    = 6'h17;
   localparam logic [5:0] IDX_LOWF_N2    = 6'h18;
   localparam logic [5:0] IDX_SPAN       = 6'h19;
   localparam logic [5:0] IDX_LOW_CODE   = 6'h1A;
   localparam logic [5:0] IDX_HIGH_CODE  = 6'h1B;
   localparam logic [5:0] IDX_CUR_CODE   = 6'h1C;
   localparam logic [5:0] IDX_GO         = 6'h1D;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] IDX_IRQ_MASK   = 6'h21;

   //----------------------------------------------------------------
   // Reset values
   //----------------------------------------------------------------
   localparam logic [7:0] RST_AMP_TRIM   = 8'h08;
   localparam logic [7:0] RST_PHASE_TRIM = 8'h20;
   localparam logic [7:0] RST_LOWF_B0    = 8'h55;
   localparam logic [7:0] RST_LOWF_B1    = 8'h55;
   localparam logic [7:0] RST_LOWF_N2    = 8'h09;
   localparam logic [7:0] RST_SPAN       = 8'h07;
   localparam logic [7:0] RST_CODE       = 8'h00;
   localparam logic [7:0] RST_GO         = 8'h00;
   localparam logic [1:0] RST_IRQ        = 2'h0;

   //----------------------------------------------------------------
   // Field positions
   //----------------------------------------------------------------
   localparam int BIT_LNA_PAT    = 5;
   localparam int BIT_MIX_PAT    = 4;
   localparam int BIT_FORCE_MODE = 7;
   localparam int BIT_GO         = 0;
   localparam int IRQ_CAL_DONE   = 0;
   localparam int IRQ_CODE_UPD   = 1;

   //----------------------------------------------------------------
   // Types
   //----------------------------------------------------------------
   typedef struct packed {
      logic       lnaIqPatternEn;
      logic       mixerIqPatternEn;
      logic [3:0] iqAmplitudeTrim;
      logic [5:0] iqPhaseTrim;
   } ocq_trim_s;

   typedef struct packed {
      logic [CODE_W-1:0] lowCode;
      logic [CODE_W-1:0] highCode;
   } ocq_cal_result_s;

   typedef enum logic {SEQ_IDLE, SEQ_RUN} ocq_seq_state_e;

   // Span code to multiples of 1.125 MHz; illegal codes give zero span
   function automatic logic [UNITS_W-1:0] span_units(input logic [SPAN_W-1:0] code);
      case (code)
         5'h00:   span_units = 6'h01;
         5'h01:   span_units = 6'h02;
         5'h03:   span_units = 6'h04;
         5'h07:   span_units = 6'h08;
         5'h0F:   span_units = 6'h10;
         5'h1F:   span_units = 6'h20;
         default: span_units = 6'h00;
      endcase
   endfunction

endpackage

// *** ocq_cal_seq.sv ***
// Calibration start/complete sequencer behind the start bit
`timescale 1ns/100ps
module ocq_cal_seq
   import ocq_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic goWr,
   input  wire logic goVal,
   input  wire logic calDone,
   output logic      busy,
   output logic      donePulse
);

   ocq_seq_state_e state_reg;

   //----------------------------------------------------------------
   // State: a written one starts, completion or a written zero ends
   //----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= SEQ_IDLE;
      end else begin
         unique case (state_reg)
            SEQ_IDLE: begin
               if (goWr && goVal) begin
                  state_reg <= SEQ_RUN;
               end
            end
            SEQ_RUN: begin
               if (goWr) begin
                  state_reg <= goVal ? SEQ_RUN : SEQ_IDLE;
               end else if (calDone) begin
                  state_reg <= SEQ_IDLE;
               end
            end
         endcase
      end
   end

   // Completion strobe, only while a run is open
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         donePulse <= 1'b0;
      end else begin
         donePulse <= calDone && (state_reg == SEQ_RUN);
      end
   end

   assign busy = (state_reg == SEQ_RUN);

endmodule

// *** ocq_irq_ctrl.sv ***
// Sticky event status, read-to-clear, mask and level interrupt
`timescale 1ns/100ps
module ocq_irq_ctrl
   import ocq_pkg::*;
#(
   parameter int N = IRQ_NUM
)(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [N-1:0] events,
   input  wire logic         statusRd,
   input  wire logic         maskWr,
   input  wire logic [N-1:0] maskData,
   output logic [N-1:0]      status_reg,
   output logic [N-1:0]      mask_reg,
   output logic              irq_reg
);

   // Status: a new event wins over the read clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         status_reg <= N'(RST_IRQ);
      end else begin
         status_reg <= (status_reg & ~{N{statusRd}}) | events;
      end
   end

   // Mask
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mask_reg <= N'(RST_IRQ);
      end else if (maskWr) begin
         mask_reg <= maskData;
      end
   end

   // Level interrupt
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

endmodule

// *** ocq_trim_regs.sv ***
// Trim and oscillator calibration register bank with APB slave
`timescale 1ns/100ps
module ocq_trim_regs
   import ocq_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [APB_AW-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Radio and calibration engine
   input  wire logic                  radioOnCmd,
   input  wire logic [CODE_W-1:0]     engineCode,
   input  wire logic                  calDone,
   input  wire ocq_cal_result_s       calResult,
   // Analog controls
   output ocq_trim_s                  trimOut,
   output logic [FREQ_W-1:0]          oscCalLowFreq,
   output logic [UNITS_W-1:0]         oscCalSpanUnits,
   output logic                       oscCalGo,
   output logic [CODE_W-1:0]          appliedCode,
   output logic                       irq
);

   //----------------------------------------------------------------
   // Address decode helpers
   //----------------------------------------------------------------

   // Word index of an aligned byte address
   function automatic logic [5:0] word_idx(input logic [APB_AW-1:0] a);
      word_idx = a[7:2];
   endfunction

   // Aligned and inside the map
   function automatic logic is_mapped(input logic [APB_AW-1:0] a);
      logic [5:0] i;
      i = a[7:2];
      is_mapped = (a[1:0] == 2'h0) &&
                  (((i >= IDX_AMP_TRIM) && (i <= IDX_GO)) ||
                   (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK));
   endfunction

   //----------------------------------------------------------------
   // Declarations
   //----------------------------------------------------------------
   logic                  accessPhase;
   logic                  apbDone;
   logic                  wrDone;
   logic                  rdDone;
   logic [5:0]            idx;
   logic [31:0]           rdData_next;
   logic                  pready_reg;
   logic [31:0]           prdata_reg;
   logic                  pslverr_reg;
   logic [7:0]            ampTrim_reg;
   logic [7:0]            phaseTrim_reg;
   logic [7:0]            lowFreqB0_reg;
   logic [7:0]            lowFreqB1_reg;
   logic [7:0]            lowFreqN2_reg;
   logic [7:0]            upperSpan_reg;
   logic [7:0]            lowCode_reg;
   logic [7:0]            highCode_reg;
   logic                  forceMode_reg;
   logic [CODE_W-1:0]     forcedCode_reg;
   logic [CODE_W-1:0]     autoCode_reg;
   logic [7:1]            goSpare_reg;
   logic [FREQ_W-1:0]     lowFreq_reg;
   logic [UNITS_W-1:0]    spanUnits_reg;
   logic [CODE_W-1:0]     appliedCode_reg;
   logic [CODE_W-1:0]     currentCode;
   logic                  wrAmp;
   logic                  wrPhase;
   logic                  wrLowF0;
   logic                  wrLowF1;
   logic                  wrLowF2;
   logic                  wrSpan;
   logic                  wrLowCode;
   logic                  wrHighCode;
   logic                  wrCurCode;
   logic                  wrGo;
   logic                  wrMask;
   logic                  rdStatus;
   logic                  calBusy;
   logic                  calDonePulse;
   logic                  codeUpdate;
   logic [IRQ_NUM-1:0]    irqEvents;
   logic [IRQ_NUM-1:0]    irqStatus;
   logic [IRQ_NUM-1:0]    irqMask;
   logic                  irq_reg;

   //----------------------------------------------------------------
   // APB handshake: one wait state, answer registered
   //----------------------------------------------------------------

   // Transfer phases
   assign accessPhase = psel & penable;
   assign apbDone     = accessPhase & pready_reg;
   assign wrDone      = apbDone & pwrite & is_mapped(paddr);
   assign rdDone      = apbDone & ~pwrite & is_mapped(paddr);
   assign idx         = word_idx(paddr);

   // Ready rises in the second access cycle, falls after completion
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= accessPhase & ~pready_reg;
      end
   end

   // Read data and error captured in the first access cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (accessPhase && !pready_reg) begin
         prdata_reg  <= pwrite ? 32'h0000_0000 : rdData_next;
         pslverr_reg <= ~is_mapped(paddr);
      end else begin
         pslverr_reg <= 1'b0;
      end
   end

   // Per-register write strobes and read-clear strobe
   assign wrAmp      = wrDone && (idx == IDX_AMP_TRIM);
   assign wrPhase    = wrDone && (idx == IDX_PHASE_TRIM);
   assign wrLowF0    = wrDone && (idx == IDX_LOWF_B0);
   assign wrLowF1    = wrDone && (idx == IDX_LOWF_B1);
   assign wrLowF2    = wrDone && (idx == IDX_LOWF_N2);
   assign wrSpan     = wrDone && (idx == IDX_SPAN);
   assign wrLowCode  = wrDone && (idx == IDX_LOW_CODE);
   assign wrHighCode = wrDone && (idx == IDX_HIGH_CODE);
   assign wrCurCode  = wrDone && (idx == IDX_CUR_CODE);
   assign wrGo       = wrDone && (idx == IDX_GO);
   assign wrMask     = wrDone && (idx == IDX_IRQ_MASK);
   assign rdStatus   = rdDone && (idx == IDX_IRQ_STATUS);

   //----------------------------------------------------------------
   // I/Q trims
   //----------------------------------------------------------------

   // Amplitude trim and pattern enables
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ampTrim_reg <= RST_AMP_TRIM;
      end else if (wrAmp) begin
         ampTrim_reg <= pwdata[7:0];
      end
   end

   // Phase trim
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phaseTrim_reg <= RST_PHASE_TRIM;
      end else if (wrPhase) begin
         phaseTrim_reg <= pwdata[7:0];
      end
   end

   // Trim fields to the analog side
   assign trimOut.lnaIqPatternEn   = ampTrim_reg[BIT_LNA_PAT];
   assign trimOut.mixerIqPatternEn = ampTrim_reg[BIT_MIX_PAT];
   assign trimOut.iqAmplitudeTrim  = ampTrim_reg[3:0];
   assign trimOut.iqPhaseTrim      = phaseTrim_reg[5:0];

   //----------------------------------------------------------------
   // Calibration limits
   //----------------------------------------------------------------

   // Lower-limit frequency bytes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lowFreqB0_reg <= RST_LOWF_B0;
         lowFreqB1_reg <= RST_LOWF_B1;
         lowFreqN2_reg <= RST_LOWF_N2;
      end else begin
         if (wrLowF0) begin
            lowFreqB0_reg <= pwdata[7:0];
         end
         if (wrLowF1) begin
            lowFreqB1_reg <= pwdata[7:0];
         end
         if (wrLowF2) begin
            lowFreqN2_reg <= pwdata[7:0];
         end
      end
   end

   // Combined 20-bit lower limit
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lowFreq_reg <= {RST_LOWF_N2[3:0], RST_LOWF_B1, RST_LOWF_B0};
      end else begin
         lowFreq_reg <= {lowFreqN2_reg[3:0], lowFreqB1_reg, lowFreqB0_reg};
      end
   end

   // Upper span code
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         upperSpan_reg <= RST_SPAN;
      end else if (wrSpan) begin
         upperSpan_reg <= pwdata[7:0];
      end
   end

   // Decoded span in 1.125 MHz steps
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         spanUnits_reg <= span_units(RST_SPAN[SPAN_W-1:0]);
      end else begin
         spanUnits_reg <= span_units(upperSpan_reg[SPAN_W-1:0]);
      end
   end

   //----------------------------------------------------------------
   // Calibration run and saved codes
   //----------------------------------------------------------------

   // Start bit sequencer
   ocq_cal_seq u_seq (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .goWr      (wrGo),
      .goVal     (pwdata[BIT_GO]),
      .calDone   (calDone),
      .busy      (calBusy),
      .donePulse (calDonePulse)
   );

   // Spare bits of the start register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         goSpare_reg <= RST_GO[7:1];
      end else if (wrGo) begin
         goSpare_reg <= pwdata[7:1];
      end
   end

   // Saved codes; completion store wins over a software write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lowCode_reg  <= RST_CODE;
         highCode_reg <= RST_CODE;
      end else if (calDone && calBusy) begin
         lowCode_reg  <= {lowCode_reg[7], calResult.lowCode};
         highCode_reg <= {highCode_reg[7], calResult.highCode};
      end else begin
         if (wrLowCode) begin
            lowCode_reg <= pwdata[7:0];
         end
         if (wrHighCode) begin
            highCode_reg <= pwdata[7:0];
         end
      end
   end

   //----------------------------------------------------------------
   // Current code: automatic or forced
   //----------------------------------------------------------------

   // Mode bit
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         forceMode_reg <= RST_CODE[BIT_FORCE_MODE];
      end else if (wrCurCode) begin
         forceMode_reg <= pwdata[BIT_FORCE_MODE];
      end
   end

   // Forced code, taken only when the write selects forced mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         forcedCode_reg <= RST_CODE[CODE_W-1:0];
      end else if (wrCurCode && pwdata[BIT_FORCE_MODE]) begin
         forcedCode_reg <= pwdata[CODE_W-1:0];
      end
   end

   // Automatic code follows the engine on each radio on command
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         autoCode_reg <= RST_CODE[CODE_W-1:0];
      end else if (radioOnCmd) begin
         autoCode_reg <= engineCode;
      end
   end

   // Code in use
   assign currentCode = forceMode_reg ? forcedCode_reg : autoCode_reg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         appliedCode_reg <= RST_CODE[CODE_W-1:0];
      end else begin
         appliedCode_reg <= currentCode;
      end
   end

   //----------------------------------------------------------------
   // Interrupts
   //----------------------------------------------------------------

   // Events: calibration done, automatic code refreshed
   assign codeUpdate = radioOnCmd & ~forceMode_reg;

   always_comb begin
      irqEvents               = '0;
      irqEvents[IRQ_CAL_DONE] = calDonePulse;
      irqEvents[IRQ_CODE_UPD] = codeUpdate;
   end

   ocq_irq_ctrl #(
      .N (IRQ_NUM)
   ) u_irq (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .events     (irqEvents),
      .statusRd   (rdStatus),
      .maskWr     (wrMask),
      .maskData   (pwdata[IRQ_NUM-1:0]),
      .status_reg (irqStatus),
      .mask_reg   (irqMask),
      .irq_reg    (irq_reg)
   );

   //----------------------------------------------------------------
   // Read multiplexer
   //----------------------------------------------------------------
   always_comb begin
      rdData_next = 32'h0000_0000;
      unique case (idx)
         IDX_AMP_TRIM:   rdData_next[7:0] = ampTrim_reg;
         IDX_PHASE_TRIM: rdData_next[7:0] = phaseTrim_reg;
         IDX_LOWF_B0:    rdData_next[7:0] = lowFreqB0_reg;
         IDX_LOWF_B1:    rdData_next[7:0] = lowFreqB1_reg;
         IDX_LOWF_N2:    rdData_next[7:0] = lowFreqN2_reg;
         IDX_SPAN:       rdData_next[7:0] = upperSpan_reg;
         IDX_LOW_CODE:   rdData_next[7:0] = lowCode_reg;
         IDX_HIGH_CODE:  rdData_next[7:0] = highCode_reg;
         IDX_CUR_CODE:   rdData_next[7:0] = {forceMode_reg, currentCode};
         IDX_GO:         rdData_next[7:0] = {goSpare_reg, calBusy};
         IDX_IRQ_STATUS: rdData_next[IRQ_NUM-1:0] = irqStatus;
         IDX_IRQ_MASK:   rdData_next[IRQ_NUM-1:0] = irqMask;
         default:        rdData_next = 32'h0000_0000;
      endcase
   end

   //----------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------
   assign prdata          = prdata_reg;
   assign pready          = pready_reg;
   assign pslverr         = pslverr_reg;
   assign oscCalLowFreq   = lowFreq_reg;
   assign oscCalSpanUnits = spanUnits_reg;
   assign oscCalGo        = calBusy;
   assign appliedCode     = appliedCode_reg;
   assign irq             = irq_reg;

endmodule

// *** ocq_trim_regs_assertions.sv ***
// Concurrent checks on the trim and calibration register bank ports
`timescale 1ns/100ps
module ocq_trim_regs_assertions
   import ocq_pkg::*;
(
   input wire logic               clk_sys,
   input wire logic               rst,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [APB_AW-1:0]  paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pready,
   input wire logic               radioOnCmd,
   input wire logic [CODE_W-1:0]  engineCode,
   input wire logic               calDone,
   input wire ocq_trim_s          trimOut,
   input wire logic [FREQ_W-1:0]  oscCalLowFreq,
   input wire logic [UNITS_W-1:0] oscCalSpanUnits,
   input wire logic               oscCalGo,
   input wire logic [CODE_W-1:0]  appliedCode
);
   //----------------------------------------------------------------
   // Helper decode
   //----------------------------------------------------------------
   logic wr;
   logic forceMode_reg;
   assign wr = psel && penable && pready && pwrite;
   // Shadow of the mode bit, so auto-mode checks know when to apply
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         forceMode_reg <= 1'b0;
      end else if (wr && paddr == {IDX_CUR_CODE, 2'b00}) begin
         forceMode_reg <= pwdata[BIT_FORCE_MODE];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   //----------------------------------------------------------------
   // Properties
   //----------------------------------------------------------------
   a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_amp_trim: assert property (wr && paddr == {IDX_AMP_TRIM, 2'b00} |=>
      trimOut[11:6] == $past(pwdata[5:0])) else $error("amplitude trim output wrong");
   a_phase_trim: assert property (wr && paddr == {IDX_PHASE_TRIM, 2'b00} |=>
      trimOut.iqPhaseTrim == $past(pwdata[5:0])) else $error("phase trim output wrong");
   a_low_nibble: assert property (wr && paddr == {IDX_LOWF_N2, 2'b00} |-> ##2
      oscCalLowFreq[19:16] == $past(pwdata[3:0], 2)) else $error("low limit nibble wrong");
   a_span_zero: assert property (wr && paddr == {IDX_SPAN, 2'b00} && pwdata[4:0] == 5'h02
      |-> ##2 oscCalSpanUnits == 6'h00) else $error("illegal span not zero");
   a_go_start: assert property (wr && paddr == {IDX_GO, 2'b00} && pwdata[0] |=> oscCalGo)
      else $error("start bit not set");
   a_go_done: assert property (oscCalGo && calDone && !wr |=> !oscCalGo)
      else $error("start bit not cleared on completion");
   a_forced_code: assert property (wr && paddr == {IDX_CUR_CODE, 2'b00} && pwdata[7]
      |-> ##2 appliedCode == $past(pwdata[6:0], 2)) else $error("forced code not applied");
   a_auto_code: assert property (radioOnCmd && !forceMode_reg && !wr
      |-> ##2 appliedCode == $past(engineCode, 2)) else $error("auto code not applied");
   cover property (oscCalGo && calDone);
   cover property (radioOnCmd && !forceMode_reg);
   cover property (pready && pwrite);
endmodule

bind ocq_trim_regs ocq_trim_regs_assertions u_chk (.clk_sys, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .radioOnCmd, .engineCode, .calDone, .trimOut,
   .oscCalLowFreq, .oscCalSpanUnits, .oscCalGo, .appliedCode);

// *** test_osc_cal_iq_trim_regs.sv ***
// Self-checking bench for the trim and calibration register bank
`timescale 1ns/100ps
module test_osc_cal_iq_trim_regs;
   import ocq_pkg::*;
   logic            clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, r;
   logic            radioOnCmd, calDone, oscCalGo, irq, e;
   logic [6:0]      engineCode, appliedCode;
   ocq_cal_result_s calResult;
   ocq_trim_s       trimOut;
   logic [19:0]     oscCalLowFreq;
   logic [5:0]      oscCalSpanUnits;
   logic [15:0]     lfsr = 16'h51F2;
   logic [15:0]     v;
   logic [7:0]      wv [8];
   logic [4:0]      sc [7] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F, 5'h02};
   logic [7:0]      rv [10] = '{8'h08, 8'h20, 8'h55, 8'h55, 8'h09, 8'h07, 8'h00,
                                8'h00, 8'h00, 8'h00};
   int              errors = 0;
   int              check_count = 0;

   ocq_trim_regs u_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .radioOnCmd, .engineCode, .calDone, .calResult,
      .trimOut, .oscCalLowFreq, .oscCalSpanUnits, .oscCalGo, .appliedCode, .irq);

   // Clock at 250 MHz
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   // Span units: thermometer codes give code plus one steps
   function automatic logic [31:0] spanExp(input logic [4:0] c);
      case (c)
         5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F: return {27'h0, c} + 32'h1;
         default: return 32'h0;
      endcase
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, then one idle edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      if (pready !== 1'b1) begin
         errors++;
         wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
      bus(1'b0, {idx, 2'b00}, 32'h0);
      chk(r, exp);
   endtask

   // Start a run, finish it with random codes, let the interrupt settle
   task automatic cal();
      bus(1'b1, {IDX_GO, 2'b00}, 32'h1);
      chk({31'h0, oscCalGo}, 32'h1);
      v = rnd();
      calResult <= v[13:0];
      calDone <= 1'b1;
      @(posedge clk_sys);
      calDone <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, oscCalGo}, 32'h0);
      bus(1'b0, {IDX_LOW_CODE, 2'b00}, 32'h0);
      chk({25'h0, r[6:0]}, {25'h0, v[13:7]});
      bus(1'b0, {IDX_HIGH_CODE, 2'b00}, 32'h0);
      chk({25'h0, r[6:0]}, {25'h0, v[6:0]});
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      radioOnCmd = 1'b0;
      engineCode = 7'h00;
      calDone = 1'b0;
      calResult = '0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      foreach (rv[i]) rdc(IDX_AMP_TRIM + 6'(i), {24'h0, rv[i]});
      chk({12'h0, oscCalLowFreq}, 32'h95555);
      chk({26'h0, oscCalSpanUnits}, 32'h8);
      $display("reset values done");
      for (int i = 0; i < 8; i++) begin
         v = rnd();
         wv[i] = v[7:0];
         bus(1'b1, {IDX_AMP_TRIM + 6'(i), 2'b00}, {24'h0, wv[i]});
         rdc(IDX_AMP_TRIM + 6'(i), {24'h0, wv[i]});
      end
      chk({20'h0, trimOut}, {20'h0, wv[0][5:0], wv[1][5:0]});
      chk({12'h0, oscCalLowFreq}, {12'h0, wv[4][3:0], wv[3], wv[2]});
      for (int i = 2; i < 5; i++) bus(1'b1, {IDX_AMP_TRIM + 6'(i), 2'b00}, 32'h0);
      foreach (sc[i]) begin
         bus(1'b1, {IDX_SPAN, 2'b00}, {27'h0, sc[i]});
         @(posedge clk_sys);
         chk({26'h0, oscCalSpanUnits}, spanExp(sc[i]));
      end
      $display("read write done");
      bus(1'b1, {IDX_IRQ_MASK, 2'b00}, 32'h1);
      cal();
      rdc(IDX_GO, 32'h0);
      rdc(IDX_IRQ_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdc(IDX_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, {IDX_IRQ_MASK, 2'b00}, 32'h0);
      cal();
      chk({31'h0, irq}, 32'h0);
      rdc(IDX_IRQ_STATUS, 32'h1);
      $display("calibration done");
      bus(1'b1, {IDX_CUR_CODE, 2'b00}, 32'h85);
      @(posedge clk_sys);
      chk({25'h0, appliedCode}, 32'h5);
      rdc(IDX_CUR_CODE, 32'h85);
      bus(1'b1, {IDX_CUR_CODE, 2'b00}, 32'h0A);
      v = rnd();
      engineCode <= v[6:0];
      radioOnCmd <= 1'b1;
      @(posedge clk_sys);
      radioOnCmd <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({25'h0, appliedCode}, {25'h0, v[6:0]});
      rdc(IDX_CUR_CODE, {25'h0, v[6:0]});
      rdc(IDX_IRQ_STATUS, 32'h2);
      $display("current code done");
      bus(1'b0, 8'h78, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      bus(1'b1, 8'h51, 32'hFF);
      chk({31'h0, e}, 32'h1);
      rdc(IDX_AMP_TRIM, {24'h0, wv[0]});
      $display("refusal done");
      wrap_up();
   end
endmodule
